//--- design/rst_pwr_ctrl.sv
// Purpose: Reset sources, power modes, OVP and charging source control
// Assumes: All pin inputs synchronous to CLK_I except RST_B_I and RST_PIN_B_I
// Notes:   POR is RST_B_I; pin reset is RST_PIN_B_I
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Function
// - Reset pin is active low, no power loss
// - Address strap sampled once after POR
// - POR, software and pin reset sources
// - Serial bus lines released during reset
// - Resets clear config, spare pin logic
// - Leave reset in OTP-selected mode
// - Off, deep standby, active power sets
// - Detect, L1, L2: detectors only
// - Mode from standby, link, connection, speed
// - Host or peripheral role, switchable
// - L1 and L2 entry and exit
// - Protocol access only customer registers, configurable
// - Protocol messages accepted in any mode but off
// - Over-voltage disables USB2 path
// - Path re-enabled below falling threshold
// - Charging source on DN while bit set
// - Connect clears charging bit and source
// - Charging allowed in peripheral role too
// - Works from defaults without configuration
module rst_pwr_ctrl
   import rst_pwr_pkg::*;
(
   // Clock and resets
   input  wire logic        CLK_I,
   input  wire logic        RST_B_I,
   input  wire logic        RST_PIN_B_I,
   // APB slave
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic [31:0]      PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   // Supplies, strap and OTP
   input  wire logic        SUPPLY_OK_I,
   input  wire logic [1:0]  ADDR_SEL_I,
   input  wire logic        OTP_DSTBY_I,
   input  wire logic        OTP_ROLE_I,
   // Link and connection status
   input  wire logic        CONNECTED_I,
   input  wire logic        HS_I,
   input  wire logic [1:0]  LINK_STATE_I,
   input  wire logic        OVP_I,
   // Protocol message register port
   input  wire logic        RAP_REQ_I,
   input  wire logic        RAP_WR_I,
   input  wire logic [7:0]  RAP_ADDR_I,
   input  wire logic [7:0]  RAP_WDATA_I,
   output logic             RAP_ACK_O,
   output logic [7:0]       RAP_RDATA_O,
   // Serial register bus enables
   output logic             SCL_OE_ALLOW_O,
   output logic             SDA_OE_ALLOW_O,
   // Power and path controls
   output logic             REGIF_PWR_O,
   output logic             FS_PWR_O,
   output logic             SE_DET_O,
   output logic             HS_PWR_O,
   output logic             USB2_PATH_EN_O,
   output logic             CHG_SRC_EN_O,
   output logic             ROLE_HOST_O,
   output logic [1:0]       TGT_ADDR_O
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset combination

   logic pin_rst_b;
   logic sw_rst_r;
   logic cfg_rst_b;

   // Pin reset synchronised before use
   rst_sync u_pin_sync (
      .clk_i   (CLK_I),
      .rst_b_i (RST_PIN_B_I & RST_B_I),
      .rst_b_o (pin_rst_b)
   );

   // Low pin or software request clears configuration
   assign cfg_rst_b = pin_rst_b & ~sw_rst_r;

   // Software reset pulse; lives in POR domain only
   // Self-clearing, so the config reset lasts exactly one cycle; a flop
   // drives the async clear, so no decode glitch can reach it
   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
         sw_rst_r <= 1'b0;
      else
         sw_rst_r <= PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == CTRL_OFS
                     && PWDATA_I[CTRL_SWRST_BIT] && !sw_rst_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strap capture, POR domain only

   typedef struct packed {
      logic       taken;
      logic [1:0] addr;
   } strap_t;

   strap_t st_r;
   strap_t st_nxt;

   // Captured once when supplies are good, then frozen
   always_comb
   begin
      st_nxt = st_r;
      if (!st_r.taken && SUPPLY_OK_I)
      begin
         st_nxt.taken = 1'b1;
         st_nxt.addr  = ADDR_SEL_I;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration and mode state

   typedef struct packed {
      logic        ctrl_loaded;
      logic        chg_en;
      logic        role_host;
      logic        rap_wr_ok;
      logic        rap_rd_ok;
      logic        dstby;
      logic [7:0]  cust;
      pwr_mode_t   mode;
      logic        path_en;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        rap_ack;
      logic [7:0]  rap_rdata;
      logic        bus_allow;
      logic        conn_d;
      logic        regif;
      logic        fs_pwr;
      logic        hs_pwr;
      logic        se_det;
   } cfg_t;

   cfg_t c_r;
   cfg_t c_nxt;

   // Register read view
   function automatic logic [31:0] read_word(input logic [7:0] a, input cfg_t c,
                                             input strap_t s);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (a)
         CTRL_OFS:  v[5:1] = {c.dstby, c.rap_rd_ok, c.rap_wr_ok, c.role_host, c.chg_en};
         STAT_OFS:  v[9:0] = {c.path_en, c.conn_d, c.mode, s.taken};
         CUST_OFS:  v[7:0] = c.cust;
         STRAP_OFS: v[1:0] = s.addr;
         default:   v = 32'h0000_0000;
      endcase
      return v;
   endfunction : read_word

   // Decides power mode from standby, connection, link and speed
   function automatic pwr_mode_t pick_mode(input logic dstby, input logic conn,
                                           input logic [1:0] link, input logic hs);
      pwr_mode_t m;
      if (dstby)
         m = MODE_DSTBY;
      else if (!conn)
         m = MODE_DETECT;
      else if (link == LINK_L1)
         m = MODE_L1;
      else if (link == LINK_L2)
         m = MODE_L2;
      else if (hs)
         m = MODE_ACT_HS;
      else
         m = MODE_ACT_FS;
      return m;
   endfunction : pick_mode

   logic apb_setup;
   logic apb_acc;
   assign apb_setup = PSEL_I && !PENABLE_I;
   assign apb_acc   = PSEL_I && PENABLE_I && c_r.pready;

   // Next-state logic
   always_comb
   begin
      c_nxt         = c_r;
      c_nxt.rap_ack = 1'b0;
      c_nxt.conn_d  = CONNECTED_I;
      // Defaults come from OTP after every reset
      if (!c_r.ctrl_loaded)
      begin
         c_nxt.ctrl_loaded = 1'b1;
         c_nxt.role_host   = OTP_ROLE_I;
         c_nxt.dstby       = OTP_DSTBY_I;
      end
      c_nxt.bus_allow = c_r.ctrl_loaded;
      // No wait state: ready asserted in the first access cycle
      c_nxt.pready  = apb_setup;
      c_nxt.pslverr = 1'b0;
      if (apb_setup)
      begin
         c_nxt.prdata  = read_word(PADDR_I, c_r, st_r);
         c_nxt.pslverr = PADDR_I > STRAP_OFS || PADDR_I[1:0] != 2'h0;
      end
      if (apb_acc && PWRITE_I && PADDR_I == CTRL_OFS)
      begin
         c_nxt.chg_en    = PWDATA_I[CTRL_CHG_BIT];
         c_nxt.role_host = PWDATA_I[CTRL_ROLE_BIT];
         c_nxt.rap_wr_ok = PWDATA_I[CTRL_RAPWR_BIT];
         c_nxt.rap_rd_ok = PWDATA_I[CTRL_RAPRD_BIT];
         c_nxt.dstby     = PWDATA_I[CTRL_DSTBY_BIT];
      end
      else if (apb_acc && PWRITE_I && PADDR_I == CUST_OFS)
         c_nxt.cust = PWDATA_I[7:0];
      // Protocol messages: customer register only, permission gated
      if (RAP_REQ_I && !c_r.rap_ack && c_r.mode != MODE_OFF)
      begin
         c_nxt.rap_ack   = 1'b1;
         c_nxt.rap_rdata = 8'hFF;
         if (RAP_ADDR_I == CUST_OFS)
         begin
            if (RAP_WR_I && c_r.rap_wr_ok)
               c_nxt.cust = RAP_WDATA_I;   // No arbitration, APB write loses
            else if (!RAP_WR_I && c_r.rap_rd_ok)
               c_nxt.rap_rdata = c_r.cust;
         end
      end
      // Connect kills charging source, wins over a same-cycle write
      if (CONNECTED_I && !c_r.conn_d)
         c_nxt.chg_en = 1'b0;
      c_nxt.mode    = pick_mode(c_nxt.dstby, CONNECTED_I, LINK_STATE_I, HS_I);
      c_nxt.path_en = !OVP_I;
      // Power set registered together with the mode it belongs to
      c_nxt.regif  = c_nxt.mode != MODE_OFF;
      c_nxt.fs_pwr = c_nxt.mode == MODE_ACT_FS;
      c_nxt.hs_pwr = c_nxt.mode == MODE_ACT_HS;
      c_nxt.se_det = c_nxt.mode inside {MODE_DETECT, MODE_L1, MODE_L2, MODE_ACT_FS};
   end

   // Configuration cleared by every reset source
   always_ff @(posedge CLK_I or negedge cfg_rst_b)
   begin
      if (!cfg_rst_b)
      begin
         // OTP defaults follow one cycle after release
         c_r           <= '0;
         c_r.rap_wr_ok <= CTRL_RST[CTRL_RAPWR_BIT];
         c_r.rap_rd_ok <= CTRL_RST[CTRL_RAPRD_BIT];
         c_r.cust      <= CUST_RST;
         c_r.mode      <= MODE_OFF;
      end
      else
         c_r <= c_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all registered

   // Power enables straight from flops; no decode glitch reaches the pins
   assign REGIF_PWR_O    = c_r.regif;
   assign FS_PWR_O       = c_r.fs_pwr;
   assign HS_PWR_O       = c_r.hs_pwr;
   assign SE_DET_O       = c_r.se_det;
   assign PRDATA_O       = c_r.prdata;
   assign PREADY_O       = c_r.pready;
   assign PSLVERR_O      = c_r.pslverr;
   assign RAP_ACK_O      = c_r.rap_ack;
   assign RAP_RDATA_O    = c_r.rap_rdata;
   assign SCL_OE_ALLOW_O = c_r.bus_allow;
   assign SDA_OE_ALLOW_O = c_r.bus_allow;
   assign USB2_PATH_EN_O = c_r.path_en;
   assign CHG_SRC_EN_O   = c_r.chg_en;
   assign ROLE_HOST_O    = c_r.role_host;
   assign TGT_ADDR_O     = st_r.addr;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   AST_OVP_OFF: assert property (@(posedge CLK_I) disable iff (!cfg_rst_b)
      OVP_I |=> !USB2_PATH_EN_O) else $error("path on during overvoltage");

   AST_OVP_ON: assert property (@(posedge CLK_I) disable iff (!cfg_rst_b)
      $fell(OVP_I) |-> ##1 USB2_PATH_EN_O) else $error("path not restored");

   AST_CONN_CHG: assert property (@(posedge CLK_I) disable iff (!cfg_rst_b)
      $rose(CONNECTED_I) |=> ##1 !CHG_SRC_EN_O) else $error("charge not cleared");

   AST_STRAP_HOLD: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      st_r.taken |=> $stable(st_r.addr)) else $error("strap changed");

   AST_SE_ONLY: assert property (@(posedge CLK_I) disable iff (!cfg_rst_b)
      c_r.mode inside {MODE_DETECT, MODE_L1, MODE_L2} |-> SE_DET_O && !HS_PWR_O && !FS_PWR_O)
      else $error("detector mode power wrong");

   AST_HS_ACT: assert property (@(posedge CLK_I) disable iff (!cfg_rst_b)
      c_r.mode == MODE_ACT_HS |-> HS_PWR_O && !FS_PWR_O) else $error("hs power wrong");

   AST_APB_WAIT: assert property (@(posedge CLK_I) disable iff (!cfg_rst_b)
      PSEL_I && !PENABLE_I |=> PREADY_O) else $error("apb ready late");

   AST_RAP_GATE: assert property (@(posedge CLK_I) disable iff (!cfg_rst_b)
      RAP_REQ_I && !RAP_ACK_O && RAP_ADDR_I != CUST_OFS && REGIF_PWR_O
      |=> RAP_ACK_O && RAP_RDATA_O == 8'hFF) else $error("rap outside customer set");

   AST_BUS_RST: assert property (@(posedge CLK_I)
      !cfg_rst_b |=> !SCL_OE_ALLOW_O && !SDA_OE_ALLOW_O) else $error("bus not released");

   AST_L1_MODE: assert property (@(posedge CLK_I) disable iff (!cfg_rst_b)
      CONNECTED_I && LINK_STATE_I == LINK_L1 && !c_nxt.dstby |=> c_r.mode == MODE_L1)
      else $error("l1 not entered");

   AST_OTP_LOAD: assert property (@(posedge CLK_I) disable iff (!cfg_rst_b)
      !c_r.ctrl_loaded |=> ROLE_HOST_O == $past(OTP_ROLE_I) && c_r.dstby == $past(OTP_DSTBY_I))
      else $error("otp defaults not loaded");

   AST_DETECT: assert property (@(posedge CLK_I) disable iff (!cfg_rst_b)
      !CONNECTED_I && !c_nxt.dstby |=> c_r.mode == MODE_DETECT && SE_DET_O && !HS_PWR_O)
      else $error("detached mode wrong");

   AST_SW_CLEAR: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      sw_rst_r |-> c_r.cust == CUST_RST && !CHG_SRC_EN_O && c_r.mode == MODE_OFF)
      else $error("software reset left config");

   AST_RAP_ACCEPT: assert property (@(posedge CLK_I) disable iff (!cfg_rst_b)
      RAP_REQ_I && !RAP_ACK_O && REGIF_PWR_O |=> RAP_ACK_O)
      else $error("rap message not accepted");

endmodule : rst_pwr_ctrl

//--- design/rst_pwr_pkg.sv
// Purpose: Shared constants for the repeater reset and power control block
// Assumes: 100 MHz single clock, APB register access
// Notes:   Offsets are byte addresses of 32-bit words
package rst_pwr_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STAT_OFS   = 8'h04;
   localparam logic [7:0] CUST_OFS   = 8'h08;
   localparam logic [7:0] STRAP_OFS  = 8'h0C;

   // Control field positions
   localparam int CTRL_SWRST_BIT  = 0;
   localparam int CTRL_CHG_BIT    = 1;
   localparam int CTRL_ROLE_BIT   = 2;
   localparam int CTRL_RAPWR_BIT  = 3;
   localparam int CTRL_RAPRD_BIT  = 4;
   localparam int CTRL_DSTBY_BIT  = 5;

   // Reset values
   localparam logic [5:0] CTRL_RST  = 6'h18;
   localparam logic [7:0] CUST_RST  = 8'h00;

   // Reset-pin synchroniser depth
   localparam int SYNC_STAGES = 2;

   // Power modes, one-hot
   typedef enum logic [6:0] {
      MODE_OFF    = 7'h01,
      MODE_DSTBY  = 7'h02,
      MODE_DETECT = 7'h04,
      MODE_L1     = 7'h08,
      MODE_L2     = 7'h10,
      MODE_ACT_FS = 7'h20,
      MODE_ACT_HS = 7'h40
   } pwr_mode_t;

   // Link states reported by the repeater core
   localparam logic [1:0] LINK_L0 = 2'h0;
   localparam logic [1:0] LINK_L1 = 2'h1;
   localparam logic [1:0] LINK_L2 = 2'h2;

endpackage : rst_pwr_pkg

//--- design/rst_sync.sv
// Purpose: Reset synchroniser, async assert and sync release
// Assumes: Active-low reset inputs
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module rst_sync
   import rst_pwr_pkg::*;
(
   // Clock and raw reset
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   // Synchronised reset
   output logic      rst_b_o
);

   logic [SYNC_STAGES-1:0] stage_r;

   // Immediate assert, release after two edges
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         stage_r <= '0;
      else
         stage_r <= {stage_r[SYNC_STAGES-2:0], 1'b1};
   end

   assign rst_b_o = stage_r[SYNC_STAGES-1];

endmodule : rst_sync

//--- verification/rap_host_model.sv
// Purpose: Controller-side model that issues protocol register messages
// Assumes: One message at a time, request held until acknowledged
// Notes:   Released lines show inverted values so stale data is never trusted
`timescale 1ns/1ps
module rap_host_model
(
   // Clock and answer
   input  wire logic       clk_i,
   input  wire logic       ack_i,
   input  wire logic [7:0] rdata_i,
   // Request
   output logic            req_o,
   output logic            wr_o,
   output logic [7:0]      addr_o,
   output logic [7:0]      wdata_o
);
   // Idle at time zero
   initial
   begin
      req_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One message; callers never overlap it with a bus access to the same word
   task xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
             output logic [7:0] q);
      int n;
      begin
         n = 0;
         @(posedge clk_i);
         req_o <= 1'b1;
         wr_o <= w;
         addr_o <= a;
         wdata_o <= d;
         do
         begin
            @(posedge clk_i);
            n++;
         end while (!ack_i && n < 50);
         q = (n < 50) ? rdata_i : 8'hEE;
         req_o <= 1'b0;
         addr_o <= ~a;
         wdata_o <= ~d;
      end
   endtask : xfer
endmodule : rap_host_model

//--- verification/repeater_reset_power_control_bench.sv
// Purpose: Self-checking bench for reset, power mode, OVP and charging control
// Assumes: Registers reached over APB, messages through the host model
// Notes:   Expected values come from package constants and literals
`timescale 1ns/1ps
module repeater_reset_power_control_bench;
   import rst_pwr_pkg::*;
   logic        clk, rst_b, rst_pin_b, psel, penable, pwrite, pready, pslverr, err;
   logic        supply_ok, otp_dstby, otp_role, connected, hs, ovp, rap_req, rap_wr, rap_ack;
   logic        scl_ok, sda_ok, regif, fs, se, hsp, path, chg, role;
   logic [1:0]  addr_sel, link_state, tgt;
   logic [7:0]  paddr, rap_addr, rap_wdata, rap_rdata, q8;
   logic [31:0] pwdata, prdata, q;
   int          n_fail, checks;
   rst_pwr_ctrl rst_pwr_ctrl_inst (.CLK_I(clk), .RST_B_I(rst_b), .RST_PIN_B_I(rst_pin_b),
      .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .SUPPLY_OK_I(supply_ok), .ADDR_SEL_I(addr_sel), .OTP_DSTBY_I(otp_dstby),
      .OTP_ROLE_I(otp_role), .CONNECTED_I(connected), .HS_I(hs), .LINK_STATE_I(link_state),
      .OVP_I(ovp), .RAP_REQ_I(rap_req), .RAP_WR_I(rap_wr), .RAP_ADDR_I(rap_addr),
      .RAP_WDATA_I(rap_wdata), .RAP_ACK_O(rap_ack), .RAP_RDATA_O(rap_rdata),
      .SCL_OE_ALLOW_O(scl_ok), .SDA_OE_ALLOW_O(sda_ok), .REGIF_PWR_O(regif), .FS_PWR_O(fs),
      .SE_DET_O(se), .HS_PWR_O(hsp), .USB2_PATH_EN_O(path), .CHG_SRC_EN_O(chg),
      .ROLE_HOST_O(role), .TGT_ADDR_O(tgt));
   rap_host_model rap_host_model_inst (.clk_i(clk), .ack_i(rap_ack), .rdata_i(rap_rdata),
      .req_o(rap_req), .wr_o(rap_wr), .addr_o(rap_addr), .wdata_o(rap_wdata));
   ////////////////////////////////////////////////////////////////////////////
   // Clock and watchdog; whole run is well under 2000 cycles
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #50us;
      n_fail++;
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task wrap_up;
      $display("Comparisons %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // Setup, then access held until pready is seen; the watchdog ends a hang
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (!pready);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Link inputs, then compare {regif, fs, se, hsp}
   task mode(input logic c, input logic h, input logic [1:0] l, input logic [3:0] e);
      connected <= c;
      hs <= h;
      link_state <= l;
      cyc(3);
      chk({regif, fs, se, hsp}, e);
   endtask : mode
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {rst_b, psel, penable, pwrite, supply_ok, otp_dstby, connected, hs, ovp} = 0;
      rst_pin_b = 1'b1;
      otp_role = 1'b1;
      addr_sel = 2'h2;
      link_state = LINK_L0;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_fail = 0;
      checks = 0;
      // Power-on reset over two edges; pin reset idles high like its pull-up
      cyc(2);
      chk({scl_ok, sda_ok, regif, role}, 32'h0);
      rst_b <= 1'b1;
      cyc(2);
      supply_ok <= 1'b1;
      cyc(4);
      chk(tgt, 32'h2);
      addr_sel <= 2'h1;
      cyc(2);
      chk(tgt, 32'h2);
      chk({scl_ok, sda_ok}, 32'h3);
      apb(0, CTRL_OFS, 0);
      chk(q, CTRL_RST | (1 << CTRL_ROLE_BIT));
      chk(role, 32'h1);
      mode(0, 0, LINK_L0, 4'hA);
      mode(1, 0, LINK_L1, 4'hA);
      mode(1, 0, LINK_L2, 4'hA);
      mode(1, 1, LINK_L0, 4'h9);
      mode(1, 0, LINK_L0, 4'hE);
      apb(1, CTRL_OFS, CTRL_RST | (1 << CTRL_DSTBY_BIT));
      mode(1, 0, LINK_L0, 4'h8);
      // Peripheral role, charging enabled while detached
      connected <= 1'b0;
      apb(1, CTRL_OFS, CTRL_RST | (1 << CTRL_CHG_BIT));
      cyc(2);
      chk({role, chg}, 32'h1);
      connected <= 1'b1;
      cyc(2);
      chk(chg, 32'h0);
      apb(0, CTRL_OFS, 0);
      chk(q[CTRL_CHG_BIT], 32'h0);
      ovp <= 1'b1;
      cyc(2);
      chk(path, 32'h0);
      ovp <= 1'b0;
      cyc(2);
      chk(path, 32'h1);
      // Messages while suspended: permitted access first, then each denial
      link_state <= LINK_L2;
      rap_host_model_inst.xfer(1, CUST_OFS, 8'hA5, q8);
      chk(q8, 32'hFF);
      apb(0, CUST_OFS, 0);
      chk(q, 32'hA5);
      rap_host_model_inst.xfer(0, CUST_OFS, 8'h00, q8);
      chk(q8, 32'hA5);
      rap_host_model_inst.xfer(1, CTRL_OFS, 8'h00, q8);
      chk(q8, 32'hFF);
      apb(0, CTRL_OFS, 0);
      chk(q, CTRL_RST);
      rap_host_model_inst.xfer(0, STRAP_OFS, 8'h00, q8);
      chk(q8, 32'hFF);
      apb(1, CTRL_OFS, CTRL_RST & ~(1 << CTRL_RAPRD_BIT));
      rap_host_model_inst.xfer(0, CUST_OFS, 8'h00, q8);
      chk(q8, 32'hFF);
      apb(1, CTRL_OFS, CTRL_RST & ~(1 << CTRL_RAPWR_BIT));
      rap_host_model_inst.xfer(1, CUST_OFS, 8'h11, q8);
      chk(q8, 32'hFF);
      apb(0, CUST_OFS, 0);
      chk(q, 32'hA5);
      apb(0, 8'h10, 0);
      chk(err, 32'h1);
      // Pin reset as host recovery after over-voltage; OTP now asks for standby
      apb(1, CUST_OFS, 32'h5A);
      otp_dstby <= 1'b1;
      rst_pin_b <= 1'b0;
      cyc(2);
      chk({scl_ok, sda_ok}, 32'h0);
      rst_pin_b <= 1'b1;
      cyc(1);
      chk(scl_ok, 32'h0);
      cyc(5);
      chk({regif, fs, se, hsp}, 32'h8);
      apb(0, CUST_OFS, 0);
      chk(q, 32'h0);
      chk({role, tgt}, 32'h6);
      apb(1, CUST_OFS, 32'h3C);
      apb(1, CTRL_OFS, CTRL_RST | (1 << CTRL_SWRST_BIT));
      cyc(3);
      apb(0, CUST_OFS, 0);
      chk(q, 32'h0);
      chk(tgt, 32'h2);
      wrap_up();
   end
endmodule : repeater_reset_power_control_bench
